// file: nvmc_pkg.sv
package nvmc_pkg;

  localparam logic [7:0] ADDR_PROG_COUNT = 8'h88;
  localparam logic [7:0] ADDR_NV_CTRL = 8'h89;
  localparam logic [7:0] ADDR_LIVE_CRC = 8'h8a;
  localparam logic [7:0] ADDR_MEM_HIGH = 8'h8b;
  localparam logic [7:0] ADDR_MEM_LOW = 8'h8c;
  localparam logic [7:0] ADDR_NV_WINDOW = 8'h8d;
  localparam logic [7:0] ADDR_SRAM_WINDOW = 8'h8e;

  localparam int BIT_REG_COMMIT = 6;
  localparam int BIT_CRC_ERR = 5;
  localparam int BIT_AUTO_CRC = 4;
  localparam int BIT_MEM_COMMIT = 3;
  localparam int BIT_BUSY = 2;
  localparam int BIT_PROG_START = 0;

  localparam logic AUTO_CRC_RESET = 1'b1;
  localparam logic [7:0] LIVE_CRC_RESET = 8'h00;
  localparam logic [11:0] MEM_ADDR_RESET = 12'h000;
  localparam logic [7:0] PROG_COUNT_RESET = 8'h00;
  localparam logic [7:0] PROG_COUNT_MAX = 8'hff;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned PROG_TIME_MS = 230;
  localparam int unsigned PROG_CYCLES_DEFAULT = PROG_TIME_MS * (CLK_HZ / 1000);

  localparam int NV_AW = 9;
  localparam int PAGE_W = 2;
  localparam int PAGE_OFS_W = 7;
  localparam logic [9:0] NV_WORDS_CNT = 10'h200;
  localparam logic [9:0] PAGE_WORDS_CNT = 10'h080;
  localparam logic [8:0] CRC_ADDR = 9'h1ff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOAD = 5'b00010,
    ST_SAVE = 5'b00100,
    ST_PROG = 5'b01000,
    ST_WAIT = 5'b10000
  } nvmc_fsm_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvmc_reg_req_t;

  typedef struct packed {
    logic wr;
    logic [8:0] addr;
    logic [7:0] data;
  } nvmc_byte_wr_t;

  typedef struct packed {
    nvmc_fsm_t fsm;
    logic aon_s1;
    logic aon_s2;
    logic [9:0] idx;
    logic [PAGE_W-1:0] page;
    logic reg_commit;
    logic mem_commit;
    logic crc_err;
    logic auto_crc;
    logic [7:0] live_crc;
    logic [11:0] mem_addr;
    logic [11:0] ptr;
    logic nv_open;
    logic ram_open;
    logic [7:0] prog_cnt;
    logic [31:0] wait_cnt;
    logic prog_pulse;
    logic nvm_rd;
    logic [8:0] nvm_addr;
    logic ld_issue;
    logic ld_v;
    logic [8:0] ld_a;
    logic sv_v;
    logic [8:0] cfg_rd_addr;
    logic pg_p1;
    logic pg_p2;
    logic [8:0] pg_a1;
    logic [8:0] pg_a2;
    logic sram_we;
    logic [8:0] sram_addr;
    logic [7:0] sram_wdata;
    logic rd_p1;
    logic rd_p2;
    logic rd_ok1;
    logic rd_ok2;
    logic [7:0] rd_a1;
    logic [7:0] rd_a2;
    logic rvalid;
    logic [7:0] rdata;
    nvmc_byte_wr_t cfg_wr;
    nvmc_byte_wr_t nv_wr;
  } nvmc_regs_t;

endpackage

// file: nvmc_sram.sv
`timescale 1ns/1ps
module nvmc_sram
  import nvmc_pkg::*;
#(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input wire logic sys_clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  // No reset on the array: each byte is undefined until that byte is written.
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule

// file: nvmc_crc8.sv
`timescale 1ns/1ps
module nvmc_crc8
  import nvmc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic en_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  logic [7:0] next_crc;

  always_comb begin
    next_crc = crc_out;
    if (clr_in) begin
      next_crc = CRC_INIT;
    end else if (en_in) begin
      next_crc = crc_out ^ data_in;
      for (int i = 0; i < 8; i++) begin
        next_crc = next_crc[7] ? ((next_crc << 1) ^ CRC_POLY) : (next_crc << 1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_out <= CRC_INIT;
    end else begin
      crc_out <= next_crc;
    end
  end
endmodule

// file: nvmc_control.sv
`timescale 1ns/1ps
module nvmc_control
  import nvmc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire nvmc_reg_req_t reg_req_in,
  input wire logic txn_end_in,
  input wire logic unlock_ok_in,
  input wire logic aon_clk_running_in,
  input wire logic [PAGE_W-1:0] commit_page_select_in,
  input wire logic [7:0] nvm_rdata_in,
  input wire logic [7:0] cfg_rd_data_in,
  output logic reg_rd_ready_out,
  output logic reg_rvalid_out,
  output logic [7:0] reg_rdata_out,
  output logic nvm_rd_out,
  output logic [8:0] nvm_rd_addr_out,
  output nvmc_byte_wr_t nvm_wr_out,
  output logic nvm_prog_start_out,
  output nvmc_byte_wr_t cfg_wr_out,
  output logic [8:0] cfg_rd_addr_out,
  output logic [11:0] indirect_mem_address_out,
  output logic program_busy_out
);
  localparam nvmc_regs_t S_RESET = '{
    fsm: ST_LOAD,
    auto_crc: AUTO_CRC_RESET,
    live_crc: LIVE_CRC_RESET,
    mem_addr: MEM_ADDR_RESET,
    prog_cnt: PROG_COUNT_RESET,
    default: '0
  };

  nvmc_regs_t s;
  nvmc_regs_t next_s;
  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_data;
  logic [7:0] crc_q;
  logic [7:0] sram_rdata;
  logic [11:0] eff_nv;
  logic [11:0] eff_ram;
  logic [7:0] prog_byte;
  logic busy;

  nvmc_sram #(.AW(NV_AW), .DW(8)) u_sram (
    .sys_clk_in(sys_clk_in),
    .we_in(s.sram_we),
    .addr_in(s.sram_addr),
    .wdata_in(s.sram_wdata),
    .rdata_out(sram_rdata)
  );

  nvmc_crc8 u_crc (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clr_in(crc_clr),
    .en_in(crc_en),
    .data_in(crc_data),
    .crc_out(crc_q)
  );

  assign busy = (s.fsm == ST_PROG) || (s.fsm == ST_WAIT);
  // Windows start at the indirect address and then step on from the last one used.
  assign eff_nv = s.nv_open ? (s.ptr + 12'h001) : s.mem_addr;
  assign eff_ram = s.ram_open ? (s.ptr + 12'h001) : s.mem_addr;
  assign prog_byte = (s.auto_crc && s.pg_a2 == CRC_ADDR) ? crc_q : sram_rdata;

  always_comb begin
    next_s = s;
    next_s.aon_s1 = aon_clk_running_in;
    next_s.aon_s2 = s.aon_s1;
    next_s.nvm_rd = 1'b0;
    next_s.ld_issue = 1'b0;
    next_s.ld_v = s.ld_issue;
    next_s.ld_a = s.nvm_addr;
    next_s.sv_v = 1'b0;
    next_s.pg_p1 = 1'b0;
    next_s.pg_p2 = s.pg_p1;
    next_s.pg_a2 = s.pg_a1;
    next_s.sram_we = 1'b0;
    next_s.prog_pulse = 1'b0;
    next_s.cfg_wr.wr = 1'b0;
    next_s.nv_wr.wr = 1'b0;
    next_s.rd_p1 = 1'b0;
    next_s.rd_ok1 = 1'b0;
    next_s.rd_p2 = s.rd_p1;
    next_s.rd_ok2 = s.rd_ok1;
    next_s.rd_a2 = s.rd_a1;
    next_s.rvalid = 1'b0;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_data = 8'h00;
    if (txn_end_in) begin
      next_s.nv_open = 1'b0;
      next_s.ram_open = 1'b0;
    end
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        ADDR_NV_CTRL: begin
          next_s.auto_crc = reg_req_in.wdata[BIT_AUTO_CRC];
          if (s.fsm == ST_IDLE) begin
            if (reg_req_in.wdata[BIT_MEM_COMMIT]) begin
              next_s.mem_commit = 1'b1;
              next_s.fsm = ST_LOAD;
              next_s.idx = 10'h000;
              crc_clr = 1'b1;
            end else if (reg_req_in.wdata[BIT_REG_COMMIT]) begin
              next_s.reg_commit = 1'b1;
              next_s.page = commit_page_select_in;
              next_s.fsm = ST_SAVE;
              next_s.idx = 10'h000;
            end else if (reg_req_in.wdata[BIT_PROG_START] && unlock_ok_in) begin
              // A locked start is dropped here; only the auto_crc bit of the same write still takes effect.
              next_s.fsm = ST_PROG;
              next_s.idx = 10'h000;
              next_s.wait_cnt = 32'h0000_0000;
              next_s.prog_pulse = 1'b1;
              crc_clr = 1'b1;
            end
          end
        end
        ADDR_MEM_HIGH: next_s.mem_addr[11:8] = reg_req_in.wdata[3:0];
        ADDR_MEM_LOW: next_s.mem_addr[7:0] = reg_req_in.wdata;
        ADDR_SRAM_WINDOW: begin
          if (s.fsm == ST_IDLE) begin
            next_s.ram_open = 1'b1;
            next_s.ptr = eff_ram;
            next_s.sram_we = 1'b1;
            next_s.sram_addr = eff_ram[8:0];
            next_s.sram_wdata = reg_req_in.wdata;
          end
        end
        default: ;
      endcase
    end
    if (reg_req_in.rd && reg_rd_ready_out) begin
      next_s.rd_p1 = 1'b1;
      next_s.rd_a1 = reg_req_in.addr;
      if (reg_req_in.addr == ADDR_NV_WINDOW && !busy) begin
        next_s.nv_open = 1'b1;
        next_s.ptr = eff_nv;
        next_s.nvm_rd = 1'b1;
        next_s.nvm_addr = eff_nv[8:0];
        next_s.rd_ok1 = 1'b1;
      end else if (reg_req_in.addr == ADDR_SRAM_WINDOW && s.fsm == ST_IDLE) begin
        next_s.ram_open = 1'b1;
        next_s.ptr = eff_ram;
        next_s.sram_addr = eff_ram[8:0];
        next_s.rd_ok1 = 1'b1;
      end
    end
    if (s.rd_p2) begin
      next_s.rvalid = 1'b1;
      unique case (s.rd_a2)
        ADDR_PROG_COUNT: next_s.rdata = s.prog_cnt;
        ADDR_NV_CTRL: begin
          next_s.rdata = 8'h00;
          next_s.rdata[BIT_REG_COMMIT] = s.reg_commit;
          next_s.rdata[BIT_CRC_ERR] = s.crc_err;
          next_s.rdata[BIT_AUTO_CRC] = s.auto_crc;
          next_s.rdata[BIT_MEM_COMMIT] = s.mem_commit;
          next_s.rdata[BIT_BUSY] = busy;
        end
        ADDR_LIVE_CRC: next_s.rdata = s.live_crc;
        ADDR_MEM_HIGH: next_s.rdata = {4'h0, s.mem_addr[11:8]};
        ADDR_MEM_LOW: next_s.rdata = s.mem_addr[7:0];
        ADDR_NV_WINDOW: next_s.rdata = s.rd_ok2 ? nvm_rdata_in : 8'h00;
        ADDR_SRAM_WINDOW: next_s.rdata = s.rd_ok2 ? sram_rdata : 8'h00;
        default: next_s.rdata = 8'h00;
      endcase
    end
    unique case (s.fsm)
      ST_IDLE: ;
      ST_LOAD: begin
        // Issue stalls while the always-on clock is down; bytes in flight still land.
        if (s.aon_s2 && s.idx != NV_WORDS_CNT) begin
          next_s.nvm_rd = 1'b1;
          next_s.nvm_addr = s.idx[8:0];
          next_s.ld_issue = 1'b1;
          next_s.idx = s.idx + 10'h001;
        end
        if (s.ld_v) begin
          if (s.ld_a != CRC_ADDR) begin
            next_s.cfg_wr = '{wr: 1'b1, addr: s.ld_a, data: nvm_rdata_in};
            crc_en = 1'b1;
            crc_data = nvm_rdata_in;
          end else begin
            next_s.crc_err = (nvm_rdata_in != crc_q);
            next_s.live_crc = crc_q;
            next_s.mem_commit = 1'b0;
            next_s.fsm = ST_IDLE;
          end
        end
      end
      ST_SAVE: begin
        if (s.idx != PAGE_WORDS_CNT) begin
          next_s.cfg_rd_addr = s.idx[8:0];
          next_s.sv_v = 1'b1;
          next_s.idx = s.idx + 10'h001;
        end
        if (s.sv_v) begin
          next_s.sram_we = 1'b1;
          next_s.sram_addr = {s.page, s.cfg_rd_addr[PAGE_OFS_W-1:0]};
          next_s.sram_wdata = cfg_rd_data_in;
          if (s.idx == PAGE_WORDS_CNT) begin
            next_s.reg_commit = 1'b0;
            next_s.fsm = ST_IDLE;
          end
        end
      end
      ST_PROG: begin
        next_s.wait_cnt = s.wait_cnt + 32'h0000_0001;
        if (s.idx != NV_WORDS_CNT) begin
          next_s.sram_addr = s.idx[8:0];
          next_s.pg_p1 = 1'b1;
          next_s.pg_a1 = s.idx[8:0];
          next_s.idx = s.idx + 10'h001;
        end
        if (s.pg_p2) begin
          next_s.nv_wr = '{wr: 1'b1, addr: s.pg_a2, data: prog_byte};
          if (s.pg_a2 != CRC_ADDR) begin
            crc_en = 1'b1;
            crc_data = sram_rdata;
          end else begin
            next_s.fsm = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        next_s.wait_cnt = s.wait_cnt + 32'h0000_0001;
        if (s.wait_cnt >= PROG_CYCLES - 1) begin
          next_s.fsm = ST_IDLE;
          if (s.prog_cnt != PROG_COUNT_MAX) begin
            next_s.prog_cnt = s.prog_cnt + 8'h01;
          end
        end
      end
      default: next_s.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= S_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Reads would return half-loaded registers, so they wait out the load.
  assign reg_rd_ready_out = (s.fsm != ST_LOAD);
  assign reg_rvalid_out = s.rvalid;
  assign reg_rdata_out = s.rdata;
  assign nvm_rd_out = s.nvm_rd;
  assign nvm_rd_addr_out = s.nvm_addr;
  assign nvm_wr_out = s.nv_wr;
  assign nvm_prog_start_out = s.prog_pulse;
  assign cfg_wr_out = s.cfg_wr;
  assign cfg_rd_addr_out = s.cfg_rd_addr;
  assign indirect_mem_address_out = s.mem_addr;
  assign program_busy_out = busy;

  chk_prog_start_taken: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (reg_req_in.wr && reg_req_in.addr == ADDR_NV_CTRL && reg_req_in.wdata[BIT_PROG_START]
     && !reg_req_in.wdata[BIT_MEM_COMMIT] && !reg_req_in.wdata[BIT_REG_COMMIT]
     && unlock_ok_in && s.fsm == ST_IDLE) |=> (program_busy_out && nvm_prog_start_out))
    else $error("Unlocked program start did not begin a cycle.");

  chk_locked_start_dropped: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (reg_req_in.wr && reg_req_in.addr == ADDR_NV_CTRL && reg_req_in.wdata[BIT_PROG_START]
     && !unlock_ok_in && s.fsm == ST_IDLE) |=> (!program_busy_out && $stable(s.prog_cnt)))
    else $error("Locked program start changed busy or count.");

  chk_busy_holds_cycle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(program_busy_out) |-> program_busy_out[*8])
    else $error("Busy dropped early in the program cycle.");

  chk_count_step_sat: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(program_busy_out) |-> ((s.prog_cnt == $past(s.prog_cnt) + 8'h01)
      || ($past(s.prog_cnt) == PROG_COUNT_MAX && s.prog_cnt == PROG_COUNT_MAX)))
    else $error("Program count did not step or saturate.");

  chk_busy_no_access: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    program_busy_out |-> !nvm_rd_out)
    else $error("Memory read issued while busy.");

  chk_commit_blocks_reads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s.mem_commit |-> !reg_rd_ready_out)
    else $error("Register read accepted during memory load.");

  chk_read_answer_time: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (reg_req_in.rd && reg_rd_ready_out) |-> ##3 reg_rvalid_out)
    else $error("Register read not answered three cycles later.");

  chk_save_page_addr: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ($past(s.fsm) == ST_SAVE && s.sram_we) |-> (s.sram_addr[8:7] == s.page))
    else $error("Register copy wrote outside the selected page.");

  chk_load_stall_aon: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s.fsm == ST_LOAD && !s.aon_s2) |=> !nvm_rd_out)
    else $error("Load advanced without the always-on clock.");

  chk_live_crc_latch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(s.mem_commit) |-> (s.live_crc == $past(crc_q)))
    else $error("Live CRC not captured at end of load.");

  chk_idle_no_commit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s.fsm == ST_IDLE) |-> (!s.mem_commit && !s.reg_commit))
    else $error("Commit bit still set in idle.");

  chk_crc_err_verdict: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ($past(s.fsm) == ST_LOAD && s.fsm == ST_IDLE)
      |-> (s.crc_err == ($past(nvm_rdata_in) != $past(crc_q))))
    else $error("CRC error flag disagrees with the stored byte.");

  chk_window_nine_bits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (nvm_rd_out && $past(s.fsm) == ST_IDLE) |-> (nvm_rd_addr_out == s.ptr[8:0]))
    else $error("Window read address is not the low nine pointer bits.");
endmodule

// file: nvmc_nvm_model.sv
`timescale 1ns/1ps
module nvmc_nvm_model
  import nvmc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rd_in,
  input wire logic [8:0] addr_in,
  input wire nvmc_byte_wr_t wr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:511];
  initial rdata_out = 8'h00;
  always @(posedge sys_clk_in) begin
    if (wr_in.wr) begin
      mem[wr_in.addr] <= wr_in.data;
    end
    // Between reads the bus inverts its last value each cycle, so a stale byte shows again on every second idle cycle.
    rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
  end
endmodule

// file: test_nonvolatile_memory_control.sv
`timescale 1ns/1ps
module test_nonvolatile_memory_control
  import nvmc_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  nvmc_reg_req_t req = '0;
  logic txn = 1'b0;
  logic unlock = 1'b0;
  logic aon = 1'b1;
  logic [1:0] page = 2'h0;
  logic [7:0] nvm_rdata;
  logic [8:0] cfg_ra;
  logic ready;
  logic rvalid;
  logic [7:0] rdata;
  logic nvm_rd;
  logic [8:0] nvm_ra;
  nvmc_byte_wr_t nvm_wr;
  nvmc_byte_wr_t cfg_wr;
  logic prog_start;
  logic [11:0] ind_addr;
  logic busy;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int cfg_cnt = 0;
  int rv_cnt = 0;
  int busy_cyc = 0;
  int starts = 0;
  int nvw_cnt = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  nvmc_control #(.PROG_CYCLES(600)) dut_u (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .reg_req_in(req),
    .txn_end_in(txn),
    .unlock_ok_in(unlock),
    .aon_clk_running_in(aon),
    .commit_page_select_in(page),
    .nvm_rdata_in(nvm_rdata),
    .cfg_rd_data_in(cfg_ra[7:0] ^ 8'h3c),
    .reg_rd_ready_out(ready),
    .reg_rvalid_out(rvalid),
    .reg_rdata_out(rdata),
    .nvm_rd_out(nvm_rd),
    .nvm_rd_addr_out(nvm_ra),
    .nvm_wr_out(nvm_wr),
    .nvm_prog_start_out(prog_start),
    .cfg_wr_out(cfg_wr),
    .cfg_rd_addr_out(cfg_ra),
    .indirect_mem_address_out(ind_addr),
    .program_busy_out(busy)
  );

  nvmc_nvm_model nvm_u (
    .sys_clk_in(sys_clk_in),
    .rd_in(nvm_rd),
    .addr_in(nvm_ra),
    .wr_in(nvm_wr),
    .rdata_out(nvm_rdata)
  );

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The ceiling sits well above the few thousand cycles the tests need.
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cfg_wr.wr === 1'b1) begin
      cfg_cnt++;
      chk("load byte", cfg_wr.data, nvm_u.mem[cfg_wr.addr]);
    end
    if (rvalid === 1'b1) rv_cnt++;
    if (busy === 1'b1) busy_cyc++;
    if (prog_start === 1'b1) starts++;
    if (nvm_wr.wr === 1'b1) nvw_cnt++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  function automatic logic [7:0] crc_of_mem();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 511; i++) begin
      c = c ^ nvm_u.mem[i];
      for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_in) req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge sys_clk_in) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_in) req <= '0;
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk_in);
      if (rvalid === 1'b1) break;
    end
    d = (n == 8) ? 8'hxx : rdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask

  task automatic txn_end();
    @(posedge sys_clk_in) txn <= 1'b1;
    @(posedge sys_clk_in) txn <= 1'b0;
  endtask

  task automatic wait_ready();
    for (int n = 0; n < 3000 && ready !== 1'b1; n++) @(negedge sys_clk_in);
  endtask

  task automatic t_reset();
    wait_ready();
    rdchk("control", ADDR_NV_CTRL, 8'h10);
    rdchk("live crc", ADDR_LIVE_CRC, crc_of_mem());
    rdchk("addr high", ADDR_MEM_HIGH, 8'h00);
    rdchk("addr low", ADDR_MEM_LOW, 8'h00);
    wr(ADDR_NV_CTRL, 8'h00);
    rdchk("auto crc off", ADDR_NV_CTRL, 8'h00);
    wr(ADDR_NV_CTRL, 8'h10);
    rdchk("auto crc on", ADDR_NV_CTRL, 8'h10);
    $display("reset test done");
  endtask

  task automatic t_addr();
    wr(ADDR_MEM_HIGH, 8'hff);
    wr(ADDR_MEM_LOW, 8'ha5);
    rdchk("addr high", ADDR_MEM_HIGH, 8'h0f);
    rdchk("addr low", ADDR_MEM_LOW, 8'ha5);
    chk("indirect addr", ind_addr, 12'hfa5);
    rdchk("nv first", ADDR_NV_WINDOW, nvm_u.mem[9'h1a5]);
    rdchk("nv next", ADDR_NV_WINDOW, nvm_u.mem[9'h1a6]);
    txn_end();
    rdchk("nv restart", ADDR_NV_WINDOW, nvm_u.mem[9'h1a5]);
    txn_end();
    $display("address and window test done");
  endtask

  task automatic t_sram();
    wr(ADDR_MEM_HIGH, 8'h00);
    wr(ADDR_MEM_LOW, 8'h20);
    wr(ADDR_SRAM_WINDOW, 8'h11);
    wr(ADDR_SRAM_WINDOW, 8'h22);
    txn_end();
    rdchk("sram first", ADDR_SRAM_WINDOW, 8'h11);
    rdchk("sram next", ADDR_SRAM_WINDOW, 8'h22);
    txn_end();
    $display("sram window test done");
  endtask

  task automatic t_copy();
    logic [7:0] d;
    @(posedge sys_clk_in) page <= 2'h2;
    wr(ADDR_NV_CTRL, 8'h50);
    for (int n = 0; n < 100; n++) begin
      rd(ADDR_NV_CTRL, d);
      if (d[BIT_REG_COMMIT] === 1'b0) break;
    end
    chk("copy done", d, 8'h10);
    wr(ADDR_MEM_HIGH, 8'h01);
    wr(ADDR_MEM_LOW, 8'h00);
    rdchk("page2 byte0", ADDR_SRAM_WINDOW, 8'h3c);
    rdchk("page2 byte1", ADDR_SRAM_WINDOW, 8'h3d);
    txn_end();
    $display("register copy test done");
  endtask

  task automatic t_locked();
    logic [7:0] c0;
    int s0;
    rd(ADDR_PROG_COUNT, c0);
    s0 = starts;
    wr(ADDR_NV_CTRL, 8'h11);
    repeat (10) @(negedge sys_clk_in);
    chk("busy locked", busy, 1'b0);
    chk("starts locked", starts - s0, 0);
    rdchk("count locked", ADDR_PROG_COUNT, c0);
    rdchk("start cleared", ADDR_NV_CTRL, 8'h10);
    $display("locked program test done");
  endtask

  task automatic t_prog();
    logic [7:0] c0;
    int b0;
    int s0;
    int w0;
    // The SRAM array has no reset, so every byte is written first to keep the image known.
    wr(ADDR_MEM_HIGH, 8'h00);
    wr(ADDR_MEM_LOW, 8'h00);
    for (int i = 0; i < 512; i++) wr(ADDR_SRAM_WINDOW, i[7:0] ^ 8'hc3);
    txn_end();
    rd(ADDR_PROG_COUNT, c0);
    b0 = busy_cyc;
    s0 = starts;
    w0 = nvw_cnt;
    @(posedge sys_clk_in) unlock <= 1'b1;
    wr(ADDR_NV_CTRL, 8'h11);
    for (int n = 0; n < 10 && busy !== 1'b1; n++) @(negedge sys_clk_in);
    rdchk("control busy", ADDR_NV_CTRL, 8'h14);
    rdchk("nv window busy", ADDR_NV_WINDOW, 8'h00);
    txn_end();
    for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge sys_clk_in);
    @(posedge sys_clk_in) unlock <= 1'b0;
    chk("busy length", busy_cyc - b0, 600);
    chk("start pulses", starts - s0, 1);
    chk("bytes programmed", nvw_cnt - w0, 512);
    chk("programmed byte", nvm_u.mem[9'h005], 8'h05 ^ 8'hc3);
    chk("stored crc", nvm_u.mem[511], crc_of_mem());
    rdchk("count", ADDR_PROG_COUNT, c0 + 8'h01);
    $display("program test done");
  endtask

  task automatic t_commit();
    int c0;
    int r0;
    nvm_u.mem[511] = ~crc_of_mem();
    @(posedge sys_clk_in) aon <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    c0 = cfg_cnt;
    wr(ADDR_NV_CTRL, 8'h18);
    repeat (100) @(negedge sys_clk_in);
    chk("ready in load", ready, 1'b0);
    chk("load stalled", cfg_cnt - c0, 0);
    r0 = rv_cnt;
    @(posedge sys_clk_in) req <= '{wr: 1'b0, rd: 1'b1, addr: ADDR_NV_CTRL, wdata: 8'h00};
    @(posedge sys_clk_in) req <= '0;
    repeat (8) @(negedge sys_clk_in);
    chk("read in load", rv_cnt - r0, 0);
    @(posedge sys_clk_in) aon <= 1'b1;
    wait_ready();
    chk("load bytes", cfg_cnt - c0, 511);
    rdchk("crc error", ADDR_NV_CTRL, 8'h30);
    rdchk("live crc", ADDR_LIVE_CRC, crc_of_mem());
    $display("commit test done");
  endtask

  initial begin
    for (int i = 0; i < 511; i++) nvm_u.mem[i] = i[7:0] ^ 8'h5a;
    nvm_u.mem[511] = crc_of_mem();
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_addr();
    t_sram();
    t_copy();
    t_locked();
    t_prog();
    t_commit();
    conclude();
  end
endmodule
